//--- design/nvic_cfg.svh
`ifndef NVIC_CFG_SVH
`define NVIC_CFG_SVH
`define NVIC_NUM_IRQ      32
`define NVIC_PRIO_W       2
`define NVIC_PRIO_RST     2'h0
`define NVIC_VEC_W        6
`define NVIC_VEC_NMI      6'h02
`define NVIC_VEC_IRQ_BASE 6'h10
`define NVIC_VEC_NONE     6'h00
`define NVIC_LVL_W        3
`define NVIC_LVL_NMI      3'h0
`define NVIC_LVL_IDLE     3'h7
`define NVIC_STACK_WORDS  4'h8
`define NVIC_CNT_W        4
`endif

//--- design/nvic_pkg.sv
package nvic_pkg;
  typedef enum logic [4:0] {
    NVIC_IDLE    = 5'b00001,
    NVIC_STACK   = 5'b00010,
    NVIC_HANDLER = 5'b00100,
    NVIC_UNSTACK = 5'b01000,
    NVIC_SLEEP   = 5'b10000
  } nvic_state_t;
endpackage

//--- design/nvic_arbiter.sv
`timescale 1ns/1ps
`include "nvic_cfg.svh"
module nvic_arbiter
  import nvic_pkg::*;
#(
  parameter int NUM_IRQ = 32
)(
  input  wire logic [NUM_IRQ-1:0]            i_req,
  input  wire logic [2*NUM_IRQ-1:0]          i_prio,
  output logic                               o_valid,
  output logic [5:0]                         o_num,
  output logic [`NVIC_PRIO_W-1:0]            o_prio
);
  always_comb
  begin
    o_valid = 1'b0;
    o_num   = 6'h00;
    o_prio  = 2'h3;
    // Lowest number wins among equal levels: non-strict (<=) compare from the top down
    for (int i = NUM_IRQ-1; i >= 0; i--)
    begin
      if (i_req[i] && (!o_valid || i_prio[2*i +: 2] <= o_prio)) // RULE_16
      begin
        o_valid = 1'b1;
        o_num   = 6'(i);
        o_prio  = i_prio[2*i +: 2];
      end
    end
  end
endmodule

//--- design/nvic_ctrl.sv
`timescale 1ns/1ps
`include "nvic_cfg.svh"
// Notes on behaviour
// RULE_01 - Thirty-two request lines, each given one of four priority levels.
// RULE_02 - A separate non-maskable request input outranks every ordinary line.
// RULE_03 - Each line is level or pulse sensitive by its own mode bit.
// RULE_04 - A new request preempts the running handler only when strictly more urgent.
// RULE_05 - Every taken exception runs with the core in handler state.
// RULE_06 - Accepting a request starts a vector fetch for the handler address.
// RULE_07 - Stacking of core registers runs alongside the vector fetch.
// RULE_08 - At handler end the saved registers are popped and the program resumes.
// RULE_09 - A pending request at handler end chains directly, skipping pop and push.
// RULE_10 - A more urgent request during stacking takes the vector without extra delay.
// RULE_11 - Pending enabled requests raise a wake signal to the wake-up unit.
// RULE_12 - The core sleeps on wait instructions or sleep-on-exit at handler return.
// RULE_13 - The core abandons long operations so entry latency stays fixed.
// RULE_14 - Priority 0 is most urgent, 3 least; all reset to 0, below NMI.
// RULE_15 - Disabled requests pend but never activate; active ones stay until return. Return clears act[vec[4:0]], so the returning line stays active.
// RULE_16 - Equal priority requests are taken lowest number first.
module nvic_ctrl
  import nvic_pkg::*;
#(
  parameter int NUM_IRQ = `NVIC_NUM_IRQ
)(
  input  wire logic                   I_CLK_SYS,
  input  wire logic                   I_SYS_RST,
  input  wire logic [NUM_IRQ-1:0]     i_irq,
  input  wire logic                   i_nmi,
  input  wire logic [NUM_IRQ-1:0]     i_irq_enable,
  input  wire logic [NUM_IRQ-1:0]     i_irq_pulse_mode,
  input  wire logic [2*NUM_IRQ-1:0]   i_irq_prio,
  input  wire logic                   i_prio_we,
  input  wire logic                   i_stack_ack,
  input  wire logic                   i_exc_return,
  input  wire logic                   i_wait_for_irq_instr,
  input  wire logic                   i_wait_for_event_instr,
  input  wire logic                   i_sleep_on_exit,
  output logic                        o_handler_mode,
  output logic                        o_vec_fetch,
  output logic [`NVIC_VEC_W-1:0]      o_vec_num,
  output logic                        o_stack_push,
  output logic                        o_stack_pop,
  output logic                        o_sleeping,
  output logic                        o_wake_req,
  output logic [NUM_IRQ-1:0]          o_pending,
  output logic [NUM_IRQ-1:0]          o_active
);
  nvic_state_t                 state, next_state;
  logic [NUM_IRQ-1:0]          irq_q, next_irq_q;
  logic [NUM_IRQ-1:0]          pend, next_pend;
  logic [NUM_IRQ-1:0]          act, next_act;
  logic [2*NUM_IRQ-1:0]        prio, next_prio;
  logic                        nmi_q, next_nmi_q;
  logic                        nmi_pend, next_nmi_pend;
  logic                        nmi_act, next_nmi_act;
  logic [`NVIC_VEC_W-1:0]      vec, next_vec;
  logic [`NVIC_VEC_W-1:0]      saved_vec, next_saved_vec;
  logic [`NVIC_LVL_W-1:0]      run_lvl, next_run_lvl;
  logic [`NVIC_LVL_W-1:0]      saved_lvl, next_saved_lvl;
  logic [`NVIC_CNT_W-1:0]      cnt, next_cnt;
  logic                        fetch, next_fetch;
  logic                        push, next_push;
  logic                        pop, next_pop;
  logic                        wake, next_wake;
  logic [NUM_IRQ-1:0]          events;
  logic [NUM_IRQ-1:0]          cand;
  logic                        win_valid;
  logic [5:0]                  win_num;
  logic [`NVIC_PRIO_W-1:0]     win_prio;
  logic [`NVIC_LVL_W-1:0]      win_lvl;
  logic                        take;

  function automatic logic [`NVIC_LVL_W-1:0] lvl_of(input logic [`NVIC_PRIO_W-1:0] p);
    lvl_of = {1'b0, p} + 3'h1; // RULE_14
  endfunction

  // Level lines pend while high; pulse lines pend on a rising edge
  genvar g;
  generate
    for (g = 0; g < NUM_IRQ; g++)
    begin : g_detect
      assign events[g] = i_irq_pulse_mode[g] ? (i_irq[g] & ~irq_q[g]) : i_irq[g]; // RULE_03
    end
  endgenerate

  assign cand = pend & i_irq_enable & ~act; // RULE_15

  nvic_arbiter #(
    .NUM_IRQ (NUM_IRQ)
  ) u_arb (
    .i_req   (cand),
    .i_prio  (prio),
    .o_valid (win_valid),
    .o_num   (win_num),
    .o_prio  (win_prio)
  );

  assign win_lvl = lvl_of(win_prio);

  // Strictly more urgent than what runs, NMI above all
  assign take = (nmi_pend && !nmi_act) || (win_valid && win_lvl < run_lvl); // RULE_02 RULE_04

  always_comb
  begin
    next_state     = state;
    next_irq_q     = i_irq;
    next_nmi_q     = i_nmi;
    next_pend      = pend | events; // RULE_01
    next_act       = act;
    next_prio      = i_prio_we ? i_irq_prio : prio;
    next_nmi_pend  = nmi_pend | (i_nmi & ~nmi_q); // RULE_02
    next_nmi_act   = nmi_act;
    next_vec       = vec;
    next_run_lvl   = run_lvl;
    next_saved_lvl = saved_lvl;
    next_saved_vec = saved_vec;
    next_cnt       = cnt;
    next_fetch     = 1'b0;
    next_push      = 1'b0;
    next_pop       = 1'b0;
    next_wake      = (|(pend & i_irq_enable)) | nmi_pend; // RULE_11
    unique case (state)
      NVIC_IDLE, NVIC_SLEEP:
      begin
        if (take)
        begin
          next_state = NVIC_STACK;
          next_cnt   = `NVIC_STACK_WORDS;
          next_saved_lvl = run_lvl;
          next_saved_vec = `NVIC_VEC_NONE;
          next_push  = 1'b1; // RULE_07
          next_fetch = 1'b1; // RULE_06
        end
        else if (state == NVIC_IDLE && (i_wait_for_irq_instr || i_wait_for_event_instr))
          next_state = NVIC_SLEEP; // RULE_12
      end
      NVIC_STACK:
      begin
        // Push holds only for a real save; a tail chain keeps it low
        next_push = push; // RULE_09
        if (i_stack_ack)
          next_cnt = cnt - 4'h1;
        if (i_stack_ack && cnt == 4'h1)
        begin
          next_state = NVIC_HANDLER; // RULE_05
          next_push  = 1'b0;
          // Late arrival: the winner at this edge gets the vector
          if (nmi_pend && !nmi_act) // RULE_10
          begin
            next_nmi_pend = 1'b0;
            next_nmi_act  = 1'b1;
            next_vec      = `NVIC_VEC_NMI;
            next_run_lvl  = `NVIC_LVL_NMI;
          end
          else
          begin
            next_pend[win_num[4:0]] = 1'b0;
            next_act[win_num[4:0]]  = 1'b1;
            next_vec      = `NVIC_VEC_IRQ_BASE + win_num;
            next_run_lvl  = win_lvl;
          end
          next_fetch = 1'b1; // RULE_06
        end
      end
      NVIC_HANDLER:
      begin
        if (take && !i_exc_return)
        begin
          next_state = NVIC_STACK; // RULE_04
          next_saved_lvl = run_lvl;
          next_saved_vec = vec;
          next_cnt   = `NVIC_STACK_WORDS;
          next_push  = 1'b1;
          next_fetch = 1'b1;
        end
        else if (i_exc_return)
        begin
          if (vec == `NVIC_VEC_NMI)
            next_nmi_act = 1'b0;
          else
            next_act[vec[4:0]] = 1'b0; // RULE_15
          if (win_valid && win_lvl < saved_lvl || (nmi_pend && vec != `NVIC_VEC_NMI))
          begin
            next_state   = NVIC_STACK; // RULE_09
            next_cnt     = 4'h1;
            next_run_lvl = saved_lvl;
          end
          else
          begin
            next_state = NVIC_UNSTACK; // RULE_08
            next_cnt   = `NVIC_STACK_WORDS;
            next_pop   = 1'b1;
          end
        end
      end
      NVIC_UNSTACK:
      begin
        next_pop = 1'b1;
        if (i_stack_ack)
          next_cnt = cnt - 4'h1;
        if (i_stack_ack && cnt == 4'h1)
        begin
          next_pop       = 1'b0;
          // Back to the preempted handler if one was saved, else to thread, or to sleep when i_sleep_on_exit is set
          next_run_lvl   = saved_lvl; // RULE_08
          next_vec       = saved_vec;
          next_saved_lvl = `NVIC_LVL_IDLE;
          next_saved_vec = `NVIC_VEC_NONE;
          next_state     = (saved_vec != `NVIC_VEC_NONE) ? NVIC_HANDLER :
                           (i_sleep_on_exit ? NVIC_SLEEP : NVIC_IDLE); // RULE_12
        end
      end
    endcase
  end

  always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
    begin
      state     <= NVIC_IDLE;
      irq_q     <= '0;
      pend      <= '0;
      act       <= '0;
      prio      <= {NUM_IRQ{`NVIC_PRIO_RST}}; // RULE_14
      nmi_q     <= 1'b0;
      nmi_pend  <= 1'b0;
      nmi_act   <= 1'b0;
      vec       <= `NVIC_VEC_NONE;
      run_lvl   <= `NVIC_LVL_IDLE;
      saved_lvl <= `NVIC_LVL_IDLE;
      saved_vec <= `NVIC_VEC_NONE;
      cnt       <= 4'h0;
      fetch     <= 1'b0;
      push      <= 1'b0;
      pop       <= 1'b0;
      wake      <= 1'b0;
    end
    else
    begin
      state     <= next_state;
      irq_q     <= next_irq_q;
      pend      <= next_pend;
      act       <= next_act;
      prio      <= next_prio;
      nmi_q     <= next_nmi_q;
      nmi_pend  <= next_nmi_pend;
      nmi_act   <= next_nmi_act;
      vec       <= next_vec;
      run_lvl   <= next_run_lvl;
      saved_lvl <= next_saved_lvl;
      saved_vec <= next_saved_vec;
      cnt       <= next_cnt;
      fetch     <= next_fetch;
      push      <= next_push;
      pop       <= next_pop;
      wake      <= next_wake;
    end
  end

  assign o_handler_mode = state[2] | state[1]; // RULE_05
  assign o_vec_fetch    = fetch;
  assign o_vec_num      = vec;
  assign o_stack_push   = push;
  assign o_stack_pop    = pop;
  assign o_sleeping     = state[4];
  assign o_wake_req     = wake;
  assign o_pending      = pend;
  assign o_active       = act;

  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (I_SYS_RST);

  pulse_pend_a: assert property (i_irq_pulse_mode[0] && i_irq[0] && !irq_q[0]
    |=> pend[0] || act[0]) else $error("pulse edge not pended"); // RULE_03
  no_disabled_act_a: assert property (!i_irq_enable[1] && !act[1] |=> !act[1])
    else $error("disabled line activated"); // RULE_15
  entry_push_a: assert property ((state == NVIC_IDLE) && take
    |=> push && fetch && state == NVIC_STACK) else $error("entry without push"); // RULE_07
  nmi_vec_a: assert property (nmi_pend && !nmi_act && state == NVIC_STACK && i_stack_ack
    && cnt == 4'h1 |=> vec == `NVIC_VEC_NMI) else $error("late NMI missed"); // RULE_10
  unstack_pop_a: assert property (state == NVIC_HANDLER && i_exc_return && !win_valid
    && !nmi_pend |=> pop) else $error("return without pop"); // RULE_08
  handler_mode_a: assert property (state == NVIC_HANDLER |-> o_handler_mode)
    else $error("handler state lost"); // RULE_05
  no_low_preempt_a: assert property (state == NVIC_HANDLER && !nmi_pend
    && win_valid && win_lvl >= run_lvl && !i_exc_return |=> state == NVIC_HANDLER)
    else $error("preempted by lower level"); // RULE_04
  sleep_entry_a: assert property (state == NVIC_IDLE && !take && i_wait_for_irq_instr
    |=> o_sleeping) else $error("wait did not sleep"); // RULE_12
  wake_a: assert property (nmi_pend |=> o_wake_req) else $error("no wake"); // RULE_11
  chain_quiet_a: assert property (state == NVIC_STACK && !push |=> !push) // RULE_09
    else $error("push during tail chain");

  entry_c:   cover property (state == NVIC_STACK ##[1:20] state == NVIC_HANDLER);
  chain_c:   cover property (state == NVIC_HANDLER && i_exc_return ##1 state == NVIC_STACK);
  preempt_c: cover property (state == NVIC_HANDLER && take && !i_exc_return);
endmodule

//--- verif/nvic_core_model.sv
`timescale 1ns/1ps
module nvic_core_model (
  input  wire logic I_CLK_SYS,
  input  wire logic I_SYS_RST,
  input  wire logic i_slow,
  output logic      o_stack_ack
);
  logic tog;
  // Memory port takes a stack word every cycle, or every other cycle when slow
  always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST)
    if (I_SYS_RST)
      tog <= 1'b0;
    else
      tog <= ~tog;
  assign o_stack_ack = !I_SYS_RST && (!i_slow || tog);
endmodule

//--- verif/nested_vector_irq_ctrl_tb.sv
`timescale 1ns/1ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin n_errors++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end
module nested_vector_irq_ctrl_tb;
  import nvic_pkg::*;
  logic        clk, rst, nmi, we, xr, wait_for_irq_instr, wait_for_event_instr, soe, slow, ack;
  logic        hm, vf, push, pop, slp, wk, sp, sw, sf;
  logic [31:0] irq, en, pm, pend, act, r;
  logic [63:0] prio, p;
  logic [5:0]  vec;
  int          n_errors, samples_checked, n, a, b;
  nvic_ctrl #(.NUM_IRQ(32)) i_dut (.I_CLK_SYS(clk), .I_SYS_RST(rst), .i_irq(irq),
    .i_nmi(nmi), .i_irq_enable(en), .i_irq_pulse_mode(pm), .i_irq_prio(prio),
    .i_prio_we(we), .i_stack_ack(ack), .i_exc_return(xr), .i_wait_for_irq_instr(wait_for_irq_instr),
    .i_wait_for_event_instr(wait_for_event_instr), .i_sleep_on_exit(soe), .o_handler_mode(hm),
    .o_vec_fetch(vf), .o_vec_num(vec), .o_stack_push(push), .o_stack_pop(pop),
    .o_sleeping(slp), .o_wake_req(wk), .o_pending(pend), .o_active(act));
  nvic_core_model i_core (.I_CLK_SYS(clk), .I_SYS_RST(rst), .i_slow(slow),
    .o_stack_ack(ack));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic cyc(int k);
    repeat (k) @(negedge clk);
  endtask
  task automatic do_rst;
    rst = 1'b1;
    {irq, en, pm, nmi, we, xr, wait_for_irq_instr, wait_for_event_instr, soe, slow, sp, sf} = '0;
    prio = '0;
    cyc(12);
    rst = 1'b0;
  endtask
  task automatic set_prio(logic [63:0] v);
    prio = v;
    we = 1'b1;
    cyc(1);
    we = 1'b0;
  endtask
  // Waits for the handler with number e to run, noting any push and wake seen
  task automatic wait_vec(logic [5:0] e);
    int k;
    k = 0;
    while (!(vec === e && hm === 1'b1 && push === 1'b0) && k < 80)
    begin
      cyc(1);
      sp |= push;
      sf |= vf;
      sw |= wk;
      k++;
    end
    `CHK(vec, e)
  endtask
  task automatic ret(logic [5:0] e, logic ep);
    logic sq;
    int   k;
    sq = 1'b0;
    k = 0;
    xr = 1'b1;
    cyc(1);
    xr = 1'b0;
    while (k < 80 && !(e == 0 ? (hm === 1'b0 && pop === 1'b0) : vec === e && hm === 1'b1))
    begin
      sq |= pop | push;
      cyc(1);
      k++;
    end
    `CHK(sq, ep)
    `CHK(vec, e)
  endtask
  // Most urgent request: lowest priority value, then lowest line number
  function automatic logic [5:0] pick(logic [31:0] q, logic [63:0] v);
    logic [5:0] w;
    logic [2:0] wp;
    w = '0;
    wp = 3'h4;
    for (int i = 0; i < 32; i++)
      if (q[i] && {1'b0, v[2*i+:2]} < wp)
      begin
        w = 6'(16 + i);
        wp = {1'b0, v[2*i+:2]};
      end
    return w;
  endfunction
  task automatic conclude;
    $display("comparisons=%0d mismatches=%0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    #400000;
    n_errors++;
    conclude();
  end
  initial
  begin
    n_errors = 0;
    samples_checked = 0;
    sw = 1'b0;
    void'($urandom(32'hb7a4));
    do_rst();
    `CHK({hm, vf, push, pop, slp, wk, pend, act}, 70'h0)
    repeat (4)
    begin
      n = $urandom % 32;
      do_rst();
      slow = 1'($urandom % 2);
      en = '1;
      irq[n] = 1'b1;
      wait_vec(6'(16 + n));
      `CHK({sp, sf, hm, act[n]}, 4'hf)
      irq[n] = 1'b0;
      ret(6'h00, 1'b1);
    end
    $display("test entry and return done");
    for (int k = 0; k < 2; k++)
    begin
      do_rst();
      slow = 1'(k);
      a = $urandom % 32;
      b = (a + 1 + $urandom % 31) % 32;
      r = (32'h1 << a) | (32'h1 << b);
      p = k ? {$urandom, $urandom} : 64'h0;
      set_prio(p);
      en = '1;
      irq = r;
      wait_vec(pick(r, p));
      irq = '0;
      ret(pick(r & ~(32'h1 << (pick(r, p) - 16)), p), 1'b0);
    end
    $display("test ranking and tail chain done");
    do_rst();
    n = $urandom % 32;
    irq[n] = 1'b1;
    cyc(5);
    `CHK({pend[n], act, hm}, 34'h200000000)
    en[n] = 1'b1;
    wait_vec(6'(16 + n));
    en = '0;
    cyc(3);
    `CHK(act[n], 1'b1)
    $display("test enable gating done");
    do_rst();
    set_prio(64'h28c);
    en = '1;
    irq[3] = 1'b1;
    wait_vec(6'd19);
    irq = 32'h12;
    cyc(20);
    `CHK(vec, 6'd19)
    irq[5] = 1'b1;
    wait_vec(6'd21);
    irq[5] = 1'b0;
    ret(6'd19, 1'b1);
    $display("test preemption done");
    do_rst();
    slow = 1'b1;
    set_prio(64'hc000);
    en = '1;
    irq[7] = 1'b1;
    cyc(4);
    irq[9] = 1'b1;
    wait_vec(6'd25);
    `CHK(act[7], 1'b0)
    $display("test late arrival done");
    do_rst();
    pm = '1;
    en = '1;
    n = $urandom % 32;
    irq[n] = 1'b1;
    cyc(1);
    irq[n] = 1'b0;
    wait_vec(6'(16 + n));
    nmi = 1'b1;
    wait_vec(6'h02);
    $display("test pulse and nmi done");
    for (int k = 0; k < 2; k++)
    begin
      do_rst();
      en = '1;
      wait_for_irq_instr = !k;
      wait_for_event_instr = 1'(k);
      cyc(1);
      {wait_for_irq_instr, wait_for_event_instr} = '0;
      cyc(2);
      `CHK(slp, 1'b1)
      sw = 1'b0;
      irq[0] = 1'b1;
      wait_vec(6'h10);
      `CHK(sw, 1'b1)
      irq[0] = 1'b0;
      soe = 1'b1;
      ret(6'h00, 1'b1);
      cyc(2);
      `CHK(slp, 1'b1)
    end
    $display("test sleep and wake done");
    conclude();
  end
endmodule
